// file: core/snd_pkg.sv
// Purpose: shared constants for the one-shot and melody sound generator
// Assumes: 25 MHz system clock, 32768 Hz nominal sound clock
// Notes: byte offsets on a 32-bit AXI4-Lite register bus
package snd_pkg;
    localparam int ADDR_W = 8;
    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CLK = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_SEL = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_CTL = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_BUF = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_FLAG = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_INTEN = 8'h14;
    // field positions
    localparam int CLK_DEBUG_RUN_BIT = 8;
    localparam int CLK_DIV_LSB = 4;
    localparam int CLK_SRC_LSB = 0;
    localparam int SEL_TEMPO_DURATION_SEL_LSB = 8;
    localparam int SEL_MODE_LSB = 0;
    localparam int CTL_STOP_BIT = 8;
    localparam int CTL_EN_BIT = 0;
    localparam int BUF_TIE_BIT = 15;
    localparam int BUF_REST_BIT = 14;
    localparam int BUF_LEN_LSB = 8;
    localparam int BUF_FRQ_LSB = 0;
    localparam int FLG_EMPTY_BIT = 0;
    localparam int FLG_DONE_BIT = 1;
    localparam int FLG_BUSY_BIT = 2;
    localparam int LANE_LO = 0;
    localparam int LANE_HI = 1;
    // output modes
    localparam logic [1:0] MODE_ONESHOT = 2'h1;
    localparam logic [1:0] MODE_MELODY = 2'h2;
    // divider: select above this runs at 1/1
    localparam logic [2:0] DIV_MAX_SEL = 3'h5;
    // one tempo/duration step is (selector+1)*512 sound ticks
    localparam int UNIT_SHIFT = 9;
    localparam logic [UNIT_SHIFT-1:0] UNIT_LOW = 9'h1FF;
    // sound ticks of silence before an untied note
    localparam logic [4:0] GAP_DEF = 5'h10;
    // source clock derived from the system clock
    localparam int SYS_HZ = 25_000_000;
    localparam int SND_HZ = 32768;
    localparam int SRC_DIV_DEF = SYS_HZ / SND_HZ;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_PLAY = 2'b10
    } snd_state_e;
endpackage

// file: core/snd_clkgen.sv
// Purpose: sound clock enable with divider and debug gating
// Assumes: debug_mode comes from another domain
// Notes: emits a one-cycle tick per sound clock period
`timescale 1ns/1ns
module snd_clkgen
    import snd_pkg::*;
#(
    parameter int SRC_DIV = SRC_DIV_DEF
) (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // control
    input wire logic enable,
    input wire logic debug_run,
    input wire logic debug_mode,
    input wire logic [2:0] div_sel,
    // tick
    output logic snd_tick
);
    localparam int SRC_W = $clog2(SRC_DIV + 1);

    typedef struct packed {
        logic dbg_meta;
        logic dbg_sync;
        logic [SRC_W-1:0] src_cnt;
        logic [6:0] div_cnt;
        logic tick;
    } snd_clk_s;

    snd_clk_s s;
    snd_clk_s n;
    logic src_tick;
    logic run;
    logic [6:0] mask;

    assign src_tick = s.src_cnt == SRC_W'(SRC_DIV - 1);
    assign run = enable & (debug_run | ~s.dbg_sync);
    // 1/4 .. 1/128, anything above the last select passes every source tick
    assign mask = (div_sel > DIV_MAX_SEL) ? '0 : ({7{1'b1}} >> (DIV_MAX_SEL - div_sel));

    always_comb begin
        n = s;
        n.dbg_meta = debug_mode;
        n.dbg_sync = s.dbg_meta;
        n.tick = 1'b0;
        if (run) begin
            n.src_cnt = src_tick ? '0 : s.src_cnt + SRC_W'(1);
            if (src_tick) begin
                n.div_cnt = s.div_cnt + 7'h01;
                n.tick = (s.div_cnt & mask) == mask;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign snd_tick = s.tick;

    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    a_debug_halt: assert property (s.dbg_sync && !debug_run |=> !snd_tick)
        else $error("sound tick while halted in debug");
    a_div_spacing: assert property (snd_tick && div_sel == '0 |=> !snd_tick [*3])
        else $error("sound tick faster than divide by four");
endmodule

// file: core/snd_tone.sv
// Purpose: tone waveform from period and high-time counts
// Assumes: tick is a one-cycle sound clock enable
// Notes: period is period_last+1 ticks, high for high_last+1 ticks
`timescale 1ns/1ns
module snd_tone
    import snd_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // control
    input wire logic tick,
    input wire logic restart,
    input wire logic [7:0] period_last,
    input wire logic [7:0] high_last,
    // waveform
    output logic wave
);
    typedef struct packed {
        logic [7:0] cnt;
        logic wave;
    } snd_tone_s;

    snd_tone_s s;
    snd_tone_s n;

    always_comb begin
        logic [7:0] cnt_nx;
        cnt_nx = '0;
        n = s;
        if (restart) begin
            n.cnt = '0;
            n.wave = 1'b1;
        end else if (tick) begin
            cnt_nx = (s.cnt >= period_last) ? '0 : s.cnt + 8'h01;
            n.cnt = cnt_nx;
            n.wave = cnt_nx <= high_last;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign wave = s.wave;

    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    a_tone_wrap: assert property (tick && !restart && s.cnt >= period_last |=> s.cnt == '0)
        else $error("tone counter did not wrap at period end");
    // high time may change on a tied load or a mode write, so compare with the one used
    a_duty_level: assert property (tick && !restart |=> wave == (s.cnt <= $past(high_last)))
        else $error("wave level disagrees with high time");
endmodule

// file: core/snd_top.sv
// Purpose: one-shot buzzer and melody sound generator with AXI4-Lite registers
// Assumes: single 25 MHz clock, buzzer on buzzer_out, debug_mode is a pin
// Notes: flag and control bits in registers at fixed byte offsets
//
// What this block does
// - one-shot burst uses length field as duty, tone divider as frequency.
// - writing the buffer in one-shot mode clears empty flag and starts output.
// - one-shot load moves buffer to sound register on sound clock, sets empty and busy.
// - one-shot output stops after duration, setting done and clearing busy together.
// - melody loads buffered word on tempo trigger, sets empty and busy, plays it.
// - melody with no new word at next trigger ends, sets done, clears busy.
// - rest select 0 sounds a note, 1 gives a silent rest of equal length.
// - length field gives note length in thirty-second steps of the tempo.
// - tie bit set plays previous and current note with no break.
// - tone frequency is the sound clock over tone divider plus one.
// - empty flag set on load or stop request, cleared by buffer write.
// - done flag set when output finishes, cleared by writing one or buffer write.
// - interrupt is registered: high only in the cycle after a flag and its enable are both set.
// - debug run bit keeps the sound clock running in debug mode.
// - three-bit divider select picks the sound clock division ratio.
// - writing one to stop request ends any one-shot or melody output.
// - tempo/duration selector sets melody tempo or one-shot burst length.
//
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module snd_top
    import snd_pkg::*;
#(
    parameter int SRC_DIV = SRC_DIV_DEF,
    parameter logic [4:0] GAP_TICKS = GAP_DEF
) (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // debug state of the system
    input wire logic debug_mode,
    // axi4-lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // sound output and interrupt
    output logic buzzer_out,
    output logic irq
);
    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_ok;
        logic w_ok;
        logic [ADDR_W-1:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic dbg_run;
        logic [2:0] clk_div;
        logic [1:0] clk_src;
        logic [3:0] tempo_duration_sel;
        logic [1:0] mode;
        logic enable;
        logic [15:0] buf_word;
        logic buf_full;
        logic empty_f;
        logic done_f;
        logic en_empty;
        logic en_done;
        logic [15:0] cur;
        snd_state_e state;
        logic [UNIT_SHIFT+3:0] unit_cnt;
        logic [5:0] len_cnt;
        logic [4:0] gap_cnt;
        logic irq;
        logic out;
    } snd_top_s;

    snd_top_s s;
    snd_top_s n;

    logic snd_tick;
    logic wave;
    logic busy;
    logic oneshot;
    logic melody;
    logic wr_go;
    logic wr_map;
    logic wr_clk;
    logic wr_sel;
    logic wr_ctl;
    logic wr_buf;
    logic wr_flag;
    logic wr_inten;
    logic lane_lo;
    logic lane_hi;
    logic stop_req;
    logic done_clr;
    logic unit_end;
    logic trig;
    logic load;
    logic finish;
    logic tie_in;
    logic rest_on;
    logic restart;
    logic [5:0] cur_len;
    logic [7:0] cur_frq;
    logic [7:0] high_last;

    snd_clkgen #(
        .SRC_DIV(SRC_DIV)
    ) u_clkgen (
        .clock(clock),
        .nrst(nrst),
        .enable(s.enable),
        .debug_run(s.dbg_run),
        .debug_mode(debug_mode),
        .div_sel(s.clk_div),
        .snd_tick(snd_tick)
    );

    snd_tone u_tone (
        .clock(clock),
        .nrst(nrst),
        .tick(snd_tick),
        .restart(restart),
        .period_last(cur_frq),
        .high_last(high_last),
        .wave(wave)
    );

    // register write decode
    assign wr_go = s.aw_ok & s.w_ok & ~s.bvalid;
    assign wr_clk = wr_go & (s.waddr == OFF_CLK);
    assign wr_sel = wr_go & (s.waddr == OFF_SEL);
    assign wr_ctl = wr_go & (s.waddr == OFF_CTL);
    assign wr_buf = wr_go & (s.waddr == OFF_BUF);
    assign wr_flag = wr_go & (s.waddr == OFF_FLAG);
    assign wr_inten = wr_go & (s.waddr == OFF_INTEN);
    assign wr_map = wr_clk | wr_sel | wr_ctl | wr_buf | wr_flag | wr_inten;
    assign lane_lo = s.wstrb[LANE_LO];
    assign lane_hi = s.wstrb[LANE_HI];
    assign stop_req = wr_ctl & lane_hi & s.wdata[CTL_STOP_BIT];
    assign done_clr = wr_buf | (wr_flag & lane_lo & s.wdata[FLG_DONE_BIT]);

    // sequencing
    assign busy = s.state == ST_PLAY;
    assign oneshot = s.mode == MODE_ONESHOT;
    assign melody = s.mode == MODE_MELODY;
    assign cur_len = s.cur[BUF_LEN_LSB +: 6];
    assign cur_frq = s.cur[BUF_FRQ_LSB +: 8];
    assign tie_in = s.buf_word[BUF_TIE_BIT];
    assign rest_on = melody & s.cur[BUF_REST_BIT];
    // one step is (selector+1)*512 ticks: burst length or a thirty-second note
    assign unit_end = snd_tick & (s.unit_cnt == {s.tempo_duration_sel, UNIT_LOW});
    assign trig = busy & unit_end & (~melody | (s.len_cnt == cur_len));
    // no load in a cycle that writes the buffer, so the new word is never lost
    assign load = snd_tick & s.buf_full & ~wr_buf & ~stop_req & (oneshot | melody)
                  & (~busy | oneshot | trig);
    assign finish = trig & ~load;
    assign restart = load & ~(busy & melody & tie_in);
    // melody notes keep a square wave, the duty field is their length
    assign high_last = oneshot ? {2'b00, cur_len} : {1'b0, cur_frq[7:1]};

    always_comb begin
        logic [31:0] rd;
        logic rd_hit;
        rd = '0;
        rd_hit = 1'b1;
        n = s;

        // write channel
        if (s_axi_awvalid & s.awready) begin
            n.aw_ok = 1'b1;
            n.waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid & s.wready) begin
            n.w_ok = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        if (wr_go) begin
            n.aw_ok = 1'b0;
            n.w_ok = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = wr_map ? RESP_OKAY : RESP_SLVERR;
        end else if (s.bvalid & s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        n.awready = ~n.aw_ok & ~n.bvalid;
        n.wready = ~n.w_ok & ~n.bvalid;

        // register stores; clock control is locked while enabled
        if (wr_clk & ~s.enable) begin
            if (lane_hi) begin
                n.dbg_run = s.wdata[CLK_DEBUG_RUN_BIT];
            end
            if (lane_lo) begin
                n.clk_div = s.wdata[CLK_DIV_LSB +: 3];
                n.clk_src = s.wdata[CLK_SRC_LSB +: 2];
            end
        end
        if (wr_sel) begin
            if (lane_hi) begin
                n.tempo_duration_sel = s.wdata[SEL_TEMPO_DURATION_SEL_LSB +: 4];
            end
            if (lane_lo) begin
                n.mode = s.wdata[SEL_MODE_LSB +: 2];
            end
        end
        if (wr_ctl & lane_lo) begin
            n.enable = s.wdata[CTL_EN_BIT];
        end
        if (wr_inten & lane_lo) begin
            n.en_empty = s.wdata[FLG_EMPTY_BIT];
            n.en_done = s.wdata[FLG_DONE_BIT];
        end
        if (wr_buf) begin
            if (lane_hi) begin
                n.buf_word[15:8] = s.wdata[15:8];
            end
            if (lane_lo) begin
                n.buf_word[7:0] = s.wdata[7:0];
            end
            n.buf_full = 1'b1;
        end

        // sound sequencing
        if (load) begin
            n.cur = s.buf_word;
            n.buf_full = 1'b0;
            n.state = ST_PLAY;
            n.unit_cnt = '0;
            n.len_cnt = '0;
            n.gap_cnt = (melody & ~(busy & tie_in)) ? GAP_TICKS : '0;
        end else if (busy & snd_tick) begin
            if (finish) begin
                n.state = ST_IDLE;
            end
            if (unit_end) begin
                n.unit_cnt = '0;
                n.len_cnt = s.len_cnt + 6'h01;
            end else begin
                n.unit_cnt = s.unit_cnt + 13'h0001;
            end
            if (s.gap_cnt != '0) begin
                n.gap_cnt = s.gap_cnt - 5'h01;
            end
        end
        if (stop_req) begin
            n.state = ST_IDLE;
            n.buf_full = 1'b0;
        end

        // flags: a set in the same cycle beats a clear
        n.empty_f = load | stop_req | (s.empty_f & ~wr_buf);
        n.done_f = finish | (stop_req & busy) | (s.done_f & ~done_clr);
        n.irq = (s.empty_f & s.en_empty) | (s.done_f & s.en_done);
        // rests keep timing but never drive the buzzer
        n.out = busy & s.enable & ~rest_on & (s.gap_cnt == '0) & wave & ~stop_req;

        // read channel
        case (s_axi_araddr)
            OFF_CLK: begin
                rd[CLK_DEBUG_RUN_BIT] = s.dbg_run;
                rd[CLK_DIV_LSB +: 3] = s.clk_div;
                rd[CLK_SRC_LSB +: 2] = s.clk_src;
            end
            OFF_SEL: begin
                rd[SEL_TEMPO_DURATION_SEL_LSB +: 4] = s.tempo_duration_sel;
                rd[SEL_MODE_LSB +: 2] = s.mode;
            end
            OFF_CTL: begin
                rd[CTL_EN_BIT] = s.enable;
            end
            OFF_BUF: begin
                rd[15:0] = s.buf_word;
            end
            OFF_FLAG: begin
                rd[FLG_EMPTY_BIT] = s.empty_f;
                rd[FLG_DONE_BIT] = s.done_f;
                rd[FLG_BUSY_BIT] = busy;
            end
            OFF_INTEN: begin
                rd[FLG_EMPTY_BIT] = s.en_empty;
                rd[FLG_DONE_BIT] = s.en_done;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
        if (s_axi_arvalid & s.arready) begin
            n.rvalid = 1'b1;
            n.rdata = rd;
            n.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s.rvalid & s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        n.arready = ~n.rvalid;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
            s.state <= ST_IDLE;
        end else begin
            s <= n;
        end
    end

    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign buzzer_out = s.out;
    assign irq = s.irq;

    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence seq_loaded;
        ##1 (busy && s.empty_f && !s.buf_full);
    endsequence

    a_load_flags: assert property (load |-> seq_loaded)
        else $error("load did not set busy and empty");
    a_melody_load: assert property (load && melody && busy |-> seq_loaded ##0 s.len_cnt == '0)
        else $error("melody trigger load failed");
    a_buf_clear: assert property (wr_buf && !stop_req |=> !s.empty_f && s.buf_full)
        else $error("buffer write did not clear empty");
    a_end_flags: assert property ($fell(busy) |-> s.done_f)
        else $error("busy fell without done");
    a_melody_end: assert property (melody && trig && !s.buf_full |=> !busy && s.done_f)
        else $error("melody did not end without new word");
    a_note_len: assert property (busy && melody && unit_end && s.len_cnt != cur_len
                                 && !stop_req |=> busy)
        else $error("note ended before its length");
    a_tie_nogap: assert property (load && busy && melody && tie_in |=> s.gap_cnt == '0)
        else $error("tied note inserted a break");
    a_rest_quiet: assert property (busy && rest_on ##1 busy && rest_on |-> !buzzer_out)
        else $error("buzzer toggled during rest");
    a_idle_quiet: assert property (!busy [*2] |-> !buzzer_out)
        else $error("buzzer active while idle");
    a_stop_ends: assert property (stop_req |=> !busy && s.empty_f && !s.buf_full)
        else $error("stop request did not end output");
    a_empty_set: assert property (stop_req |=> ##1 s.empty_f || wr_buf)
        else $error("empty flag lost after stop");
    a_done_clear: assert property (done_clr && !finish && !(stop_req && busy) |=> !s.done_f)
        else $error("done flag not cleared");
    a_irq_gate: assert property (irq |-> $past(s.empty_f && s.en_empty || s.done_f && s.en_done))
        else $error("interrupt without enabled flag");
endmodule

// file: dv/snd_buzzer.sv
// Purpose: passive buzzer model that measures the tone on the output pin
// Assumes: pin is sampled on the system clock, high means driven
// Notes: hi_len keeps the last completed high time in clocks
`timescale 1ns/1ns
module snd_buzzer (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // pin and control
    input wire logic pin,
    input wire logic clr,
    // measurements
    output int rises,
    output int hi_len
);
    int run;
    logic last;
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rises <= 0;
            hi_len <= 0;
            run <= 0;
            last <= 1'b0;
        end else begin
            last <= pin;
            if (clr) begin
                rises <= 0;
            end else if (pin && !last) begin
                rises <= rises + 1;
            end
            if (pin) begin
                run <= run + 1;
            end else begin
                if (last) begin
                    hi_len <= run;
                end
                run <= 0;
            end
        end
    end
endmodule

// file: dv/tb.sv
// Purpose: register level test of the one-shot and melody sound generator
// Assumes: SRC_DIV of 1 and divide select 6, so one sound tick per clock
// Notes: a step is 512 ticks at tempo 0
`timescale 1ns/1ns
`define CHK(g, e) checks_done++; if ((g) !== (e)) begin n_mismatch++; $display("Error at %0t: got %0h exp %0h", $time, g, e); end
module tb;
    import snd_pkg::*;
    logic clock = 0, nrst = 0, debug_mode = 0, clr = 0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0] wstrb = '0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, buzzer_out, irq;
    logic [1:0] bresp, rresp, r;
    logic [31:0] d;
    int n_mismatch = 0, checks_done = 0, cyc = 0, rises, hi_len, t0;
    always #20 clock = ~clock;
    snd_top #(.SRC_DIV(1)) dut_u (.clock(clock), .nrst(nrst), .debug_mode(debug_mode),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .buzzer_out(buzzer_out), .irq(irq));
    snd_buzzer bz_u (.clock(clock), .nrst(nrst), .pin(buzzer_out), .clr(clr),
        .rises(rises), .hi_len(hi_len));
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 60000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        logic done;
        done = 0;
        @(posedge clock);
        awaddr <= a;
        wdata <= v;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge clock);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                done = 1;
                bready <= 1'b0;
                `CHK(bresp, er)
            end
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic done;
        done = 0;
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge clock);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                done = 1;
                v = rdata;
                rs = rresp;
                rready <= 1'b0;
            end
        end
    endtask
    // polls the flag register until the given bit shows the wanted level
    task automatic wait_flag(input int b, input logic v);
        int n;
        n = 0;
        do begin
            rd(OFF_FLAG, d, r);
            n++;
        end while (d[b] !== v && n < 1500);
        `CHK(d[b], v)
    endtask
    initial begin
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        repeat (2) @(posedge clock);
        rd(OFF_FLAG, d, r);
        `CHK(d[2:0], 3'h0)
        rd(OFF_SEL, d, r);
        `CHK(d[15:0], 16'h0000)
        rd(8'h40, d, r);
        `CHK(r, RESP_SLVERR)
        wr(8'h40, 32'h0000FFFF, RESP_SLVERR);
        wr(OFF_CLK, 32'h00000060, RESP_OKAY);
        wr(OFF_CTL, 32'h00000001, RESP_OKAY);
        wr(OFF_CLK, 32'h00000000, RESP_OKAY);
        rd(OFF_CLK, d, r);
        `CHK(d[15:0], 16'h0060)
        $display("test registers done");
        wr(OFF_SEL, {20'h0, 4'h0, 6'h0, MODE_ONESHOT}, RESP_OKAY);
        wr(OFF_INTEN, 32'h00000002, RESP_OKAY);
        wr(OFF_BUF, 32'h00000103, RESP_OKAY);
        clr <= 1'b1;
        @(posedge clock);
        clr <= 1'b0;
        wait_flag(FLG_BUSY_BIT, 1'b1);
        `CHK(d[FLG_EMPTY_BIT], 1'b1)
        wait_flag(FLG_BUSY_BIT, 1'b0);
        `CHK(d[FLG_DONE_BIT], 1'b1)
        `CHK(hi_len, 2)
        `CHK(rises >= 127 && rises <= 129, 1'b1)
        `CHK(irq, 1'b1)
        wr(OFF_FLAG, 32'h00000002, RESP_OKAY);
        rd(OFF_FLAG, d, r);
        `CHK(d[FLG_DONE_BIT], 1'b0)
        `CHK(irq, 1'b0)
        $display("test one-shot done");
        wr(OFF_BUF, 32'h00000307, RESP_OKAY);
        wait_flag(FLG_BUSY_BIT, 1'b1);
        wr(OFF_CTL, 32'h00000101, RESP_OKAY);
        rd(OFF_FLAG, d, r);
        `CHK(d[2:0], 3'h3)
        `CHK(buzzer_out, 1'b0)
        $display("test stop done");
        debug_mode <= 1'b1;
        wr(OFF_BUF, 32'h00000103, RESP_OKAY);
        repeat (40) @(posedge clock);
        rd(OFF_FLAG, d, r);
        `CHK(d[FLG_BUSY_BIT], 1'b0)
        `CHK(d[FLG_EMPTY_BIT], 1'b0)
        debug_mode <= 1'b0;
        wait_flag(FLG_BUSY_BIT, 1'b1);
        wr(OFF_CTL, 32'h00000101, RESP_OKAY);
        $display("test debug done");
        wr(OFF_SEL, {20'h0, 4'h0, 6'h0, MODE_MELODY}, RESP_OKAY);
        wr(OFF_BUF, 32'h00000007, RESP_OKAY);
        wait_flag(FLG_EMPTY_BIT, 1'b1);
        `CHK(d[FLG_BUSY_BIT], 1'b1)
        wr(OFF_BUF, 32'h00004007, RESP_OKAY);
        wait_flag(FLG_EMPTY_BIT, 1'b1);
        `CHK(hi_len, 4)
        clr <= 1'b1;
        @(posedge clock);
        clr <= 1'b0;
        wait_flag(FLG_BUSY_BIT, 1'b0);
        `CHK(d[FLG_DONE_BIT], 1'b1)
        `CHK(rises, 0)
        `CHK(buzzer_out, 1'b0)
        $display("test melody done");
        wr(OFF_BUF, 32'h00000107, RESP_OKAY);
        t0 = cyc;
        wr(OFF_BUF, 32'h00008007, RESP_OKAY);
        wait_flag(FLG_EMPTY_BIT, 1'b1);
        // two steps of 512 ticks, plus polling slack
        `CHK(cyc - t0 >= 1020 && cyc - t0 <= 1032, 1'b1)
        clr <= 1'b1;
        @(posedge clock);
        clr <= 1'b0;
        wait_flag(FLG_BUSY_BIT, 1'b0);
        // a silent gap of 16 ticks would cost two tone periods
        `CHK(rises >= 63 && rises <= 64, 1'b1)
        $display("test tie done");
        wr(OFF_CTL, 32'h00000000, RESP_OKAY);
        wr(OFF_CLK, 32'h00000160, RESP_OKAY);
        wr(OFF_CTL, 32'h00000001, RESP_OKAY);
        debug_mode <= 1'b1;
        repeat (4) @(posedge clock);
        wr(OFF_BUF, 32'h00000103, RESP_OKAY);
        wait_flag(FLG_BUSY_BIT, 1'b1);
        debug_mode <= 1'b0;
        $display("test debug run done");
        wrap_up();
    end
endmodule
